// File: mixer_if_cfg.svh
// Offsets, field positions, reset values and widths of the mixer and IF configuration bank
`ifndef MIXER_IF_CFG_SVH
`define MIXER_IF_CFG_SVH

// ----------------------------------------------------------------------------
// Port widths, register count and bank code
// ----------------------------------------------------------------------------
`define MIF_ADDR_W        9
`define MIF_DATA_W        8
`define MIF_NUM_REGS      9
`define MIF_BANK_W        2
`define MIF_BANK_MIXER    2'h1

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define MIF_OFF_MODE_ENABLES   9'h101
`define MIF_OFF_IF_CHAIN       9'h102
`define MIF_OFF_COMMON_MODE    9'h103
`define MIF_OFF_LO_SKEW_I      9'h104
`define MIF_OFF_LO_SKEW_Q      9'h105
`define MIF_OFF_NULL_IP        9'h106
`define MIF_OFF_NULL_IN        9'h107
`define MIF_OFF_NULL_QP        9'h108
`define MIF_OFF_NULL_QN        9'h109

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define MIF_RST_MODE_ENABLES   8'h7F
`define MIF_RST_IF_CHAIN       8'h3F
`define MIF_RST_COMMON_MODE    8'h51
`define MIF_RST_LO_SKEW_I      8'h5F
`define MIF_RST_LO_SKEW_Q      8'h5F
`define MIF_RST_NULL           8'h7F
`define MIF_RD_UNMAPPED        8'h00

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define MIF_BIT_MIXER_ON       3
`define MIF_BIT_SENSE_ON       2
`define MIF_BIT_GAIN_ON        0
`define MIF_BIT_SENSE_ALWAYS   7
`define MIF_BIT_GAIN_ALWAYS    6
`define MIF_BIT_ATTEN_ON       5
`define MIF_GAIN_STAGE_HI      3
`define MIF_GAIN_STAGE_LO      1
`define MIF_TRIM_HI            6
`define MIF_TRIM_LO            0

`endif

// File: mixer_if_pkg.sv
// Types shared by the mixer and IF configuration bank
package mixer_if_pkg;

	// --------------------------------------------------------------------
	// Control word handed to the analog path
	// --------------------------------------------------------------------
	typedef struct packed {
		logic       mixerOn;
		logic       ifPowerSenseOn;
		logic       autoGainOn;
		logic       senseAlwaysRun;
		logic       gainLoopAlwaysRun;
		logic       senseRun;
		logic       gainLoopRun;
		logic       ifAttenStageOn;
		logic [2:0] ifGainStageOn;
		logic [6:0] basebandCommonLevel;
		logic [6:0] loSkewIPath;
		logic [6:0] loSkewQPath;
		logic [6:0] carrierNullIPos;
		logic [6:0] carrierNullINeg;
		logic [6:0] carrierNullQPos;
		logic [6:0] carrierNullQNeg;
	} ctrl_s;

	typedef logic [7:0] byte_t;

endpackage : mixer_if_pkg

// File: cfg_reg_cell.sv
// One read/write configuration byte with its own reset value
`timescale 1ns/10ps
module cfg_reg_cell #(
	parameter int                DataWidth = 8,
	parameter logic [DataWidth-1:0] ResetVal = '0
) (
	input  wire logic                 ref_clk,
	input  wire logic                 arst_n,
	input  wire logic                 wrHit,
	input  wire logic [DataWidth-1:0] wrData,
	output logic      [DataWidth-1:0] value
);

	logic [DataWidth-1:0] value_d;
	logic [DataWidth-1:0] value_q;

	// Load on a hit, otherwise hold
	always_comb begin
		value_d = wrHit ? wrData : value_q;
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			value_q <= ResetVal;
		end else begin
			value_q <= value_d;
		end
	end

	assign value = value_q;

endmodule : cfg_reg_cell

// File: run_gate.sv
// Decodes stored bytes into the registered control word, with power-down gating
`timescale 1ns/10ps
`include "mixer_if_cfg.svh"
module run_gate (
	input  wire logic                  ref_clk,
	input  wire logic                  arst_n,
	input  wire logic                  powerDown,
	input  wire mixer_if_pkg::byte_t   modeByte,
	input  wire mixer_if_pkg::byte_t   chainByte,
	input  wire mixer_if_pkg::byte_t   cmByte,
	input  wire mixer_if_pkg::byte_t   skewIByte,
	input  wire mixer_if_pkg::byte_t   skewQByte,
	input  wire mixer_if_pkg::byte_t   nullIpByte,
	input  wire mixer_if_pkg::byte_t   nullInByte,
	input  wire mixer_if_pkg::byte_t   nullQpByte,
	input  wire mixer_if_pkg::byte_t   nullQnByte,
	output mixer_if_pkg::ctrl_s        ctrl
);

	mixer_if_pkg::ctrl_s ctrl_d;
	mixer_if_pkg::ctrl_s ctrl_q;

	always_comb begin
		ctrl_d                     = ctrl_q;
		ctrl_d.mixerOn             = modeByte[`MIF_BIT_MIXER_ON];
		ctrl_d.ifPowerSenseOn      = modeByte[`MIF_BIT_SENSE_ON];
		ctrl_d.autoGainOn          = modeByte[`MIF_BIT_GAIN_ON];
		ctrl_d.senseAlwaysRun      = chainByte[`MIF_BIT_SENSE_ALWAYS];
		ctrl_d.gainLoopAlwaysRun   = chainByte[`MIF_BIT_GAIN_ALWAYS];
		// Detector runs in power-down, or always when overridden
		ctrl_d.senseRun            = modeByte[`MIF_BIT_SENSE_ON]
			& (chainByte[`MIF_BIT_SENSE_ALWAYS] | powerDown);
		// Gain loop runs in power-down, or always when overridden
		ctrl_d.gainLoopRun         = modeByte[`MIF_BIT_GAIN_ON]
			& (chainByte[`MIF_BIT_GAIN_ALWAYS] | powerDown);
		ctrl_d.ifAttenStageOn      = chainByte[`MIF_BIT_ATTEN_ON];
		ctrl_d.ifGainStageOn       = chainByte[`MIF_GAIN_STAGE_HI:`MIF_GAIN_STAGE_LO];
		ctrl_d.basebandCommonLevel = cmByte[`MIF_TRIM_HI:`MIF_TRIM_LO];
		ctrl_d.loSkewIPath         = skewIByte[`MIF_TRIM_HI:`MIF_TRIM_LO];
		ctrl_d.loSkewQPath         = skewQByte[`MIF_TRIM_HI:`MIF_TRIM_LO];
		ctrl_d.carrierNullIPos     = nullIpByte[`MIF_TRIM_HI:`MIF_TRIM_LO];
		ctrl_d.carrierNullINeg     = nullInByte[`MIF_TRIM_HI:`MIF_TRIM_LO];
		ctrl_d.carrierNullQPos     = nullQpByte[`MIF_TRIM_HI:`MIF_TRIM_LO];
		ctrl_d.carrierNullQNeg     = nullQnByte[`MIF_TRIM_HI:`MIF_TRIM_LO];
	end

	// Reset image matches the bank's reset bytes, power-down assumed off
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_q                     <= '0;
			ctrl_q.mixerOn             <= 1'b1;
			ctrl_q.ifPowerSenseOn      <= 1'b1;
			ctrl_q.autoGainOn          <= 1'b1;
			ctrl_q.ifAttenStageOn      <= 1'b1;
			ctrl_q.ifGainStageOn       <= 3'h7;
			ctrl_q.basebandCommonLevel <= 7'h51;
			ctrl_q.loSkewIPath         <= 7'h5F;
			ctrl_q.loSkewQPath         <= 7'h5F;
			ctrl_q.carrierNullIPos     <= 7'h7F;
			ctrl_q.carrierNullINeg     <= 7'h7F;
			ctrl_q.carrierNullQPos     <= 7'h7F;
			ctrl_q.carrierNullQNeg     <= 7'h7F;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	assign ctrl = ctrl_q;

endmodule : run_gate

// File: mixer_if_config_regs.sv
// Mixer and IF path configuration register bank behind the serial port
//
// Contract
// - Bit 3 of 0x101 turns the mixer on; resets to one.
// - Detector bit 2 and gain-loop bit 0 of 0x101 reset to one.
// - Bit 7 of 0x102: zero runs detector only in power-down; one always.
// - Bit 6 of 0x102: zero runs gain loop only in power-down; one always.
// - IF amplifier field bits 3:1 resets 0x7; attenuator bit 5 resets one.
// - Seven-bit I path LO skew trim resets 0x5F, bit 7 zero.
// - Seven-bit Q path LO skew trim at 0x105 resets 0x5F.
// - Carrier null trims reset 0x7F; software writes 0x5F for IF mode.
`timescale 1ns/10ps
`include "mixer_if_cfg.svh"
module mixer_if_config_regs #(
	parameter int AddrWidth = `MIF_ADDR_W,
	parameter int NumRegs   = `MIF_NUM_REGS
) (
	input  wire logic                    ref_clk,
	input  wire logic                    arst_n,
	input  wire logic                    regWrEn,
	input  wire logic                    regRdEn,
	input  wire logic [AddrWidth-1:0]    regAddr,
	input  wire mixer_if_pkg::byte_t     regWrData,
	input  wire logic [`MIF_BANK_W-1:0]  bankSel,
	input  wire logic                    powerDown,
	output mixer_if_pkg::byte_t          regRdData,
	output logic                         regRdValid,
	output mixer_if_pkg::ctrl_s          ctrl
);

	// ------------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------------
	localparam logic [AddrWidth-1:0] RegOffset [NumRegs] = '{
		`MIF_OFF_MODE_ENABLES,
		`MIF_OFF_IF_CHAIN,
		`MIF_OFF_COMMON_MODE,
		`MIF_OFF_LO_SKEW_I,
		`MIF_OFF_LO_SKEW_Q,
		`MIF_OFF_NULL_IP,
		`MIF_OFF_NULL_IN,
		`MIF_OFF_NULL_QP,
		`MIF_OFF_NULL_QN
	};

	localparam mixer_if_pkg::byte_t RegReset [NumRegs] = '{
		`MIF_RST_MODE_ENABLES,
		`MIF_RST_IF_CHAIN,
		`MIF_RST_COMMON_MODE,
		`MIF_RST_LO_SKEW_I,
		`MIF_RST_LO_SKEW_Q,
		`MIF_RST_NULL,
		`MIF_RST_NULL,
		`MIF_RST_NULL,
		`MIF_RST_NULL
	};

	// ------------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------------
	logic                 wrHit [NumRegs];
	logic                 rdHit [NumRegs];
	mixer_if_pkg::byte_t  regVal [NumRegs];

	genvar gi;
	generate
		for (gi = 0; gi < NumRegs; gi++) begin : g_reg
			// Full byte stored, reserved bits included
			assign wrHit[gi] = regWrEn && (regAddr == RegOffset[gi]);
			assign rdHit[gi] = (regAddr == RegOffset[gi]);

			cfg_reg_cell #(
				.DataWidth (`MIF_DATA_W),
				.ResetVal  (RegReset[gi])
			) u_cell (
				.ref_clk (ref_clk),
				.arst_n  (arst_n),
				.wrHit   (wrHit[gi]),
				.wrData  (regWrData),
				.value   (regVal[gi])
			);
		end
	endgenerate

	// ------------------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------------------
	mixer_if_pkg::byte_t rdData_d;
	mixer_if_pkg::byte_t rdData_q;
	logic                rdValid_d;
	logic                rdValid_q;

	always_comb begin
		rdData_d  = `MIF_RD_UNMAPPED;
		rdValid_d = regRdEn;
		// Other bank selections steer reads away from this bank
		if (regRdEn && (bankSel == `MIF_BANK_MIXER)) begin
			for (int i = 0; i < NumRegs; i++) begin
				if (rdHit[i]) begin
					rdData_d = regVal[i];
				end
			end
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdData_q  <= 8'h00;
			rdValid_q <= 1'b0;
		end else begin
			rdData_q  <= rdData_d;
			rdValid_q <= rdValid_d;
		end
	end

	assign regRdData  = rdData_q;
	assign regRdValid = rdValid_q;

	// ------------------------------------------------------------------------
	// Control decode
	// ------------------------------------------------------------------------
	// Common-mode code is stored as written; software computes it
	run_gate u_gate (
		.ref_clk    (ref_clk),
		.arst_n     (arst_n),
		.powerDown  (powerDown),
		.modeByte   (regVal[0]),
		.chainByte  (regVal[1]),
		.cmByte     (regVal[2]),
		.skewIByte  (regVal[3]),
		.skewQByte  (regVal[4]),
		.nullIpByte (regVal[5]),
		.nullInByte (regVal[6]),
		.nullQpByte (regVal[7]),
		.nullQnByte (regVal[8]),
		.ctrl       (ctrl)
	);

endmodule : mixer_if_config_regs

// File: mixer_if_config_regs_monitor.sv
// Port checker for the mixer and IF configuration bank
`timescale 1ns/10ps
module mixer_if_config_regs_monitor #(
	parameter int AddrWidth = 9,
	parameter int NumRegs   = 9
) (
	input wire logic                 ref_clk,
	input wire logic                 arst_n,
	input wire logic                 regWrEn,
	input wire logic                 regRdEn,
	input wire logic [AddrWidth-1:0] regAddr,
	input wire mixer_if_pkg::byte_t  regWrData,
	input wire logic [1:0]           bankSel,
	input wire logic                 powerDown,
	input wire mixer_if_pkg::byte_t  regRdData,
	input wire logic                 regRdValid,
	input wire mixer_if_pkg::ctrl_s  ctrl
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	// --------------------------------------------------------------------
	// Set at the first decode after reset release, then held until the next reset
	// --------------------------------------------------------------------
	logic liveD;
	logic liveQ;
	always_comb liveD = 1'b1;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) liveQ <= 1'b0;
		else liveQ <= liveD;
	end
	a_rd_valid_pulse: assert property (regRdEn |=> regRdValid) else $error("read not answered");
	a_no_spur_valid: assert property (!regRdEn |=> !regRdValid) else $error("spurious valid");
	a_bank_gate: assert property (regRdEn && bankSel != 2'h1 |=> regRdData == 8'h00)
		else $error("read outside bank not zero");
	a_unmap_rd: assert property (regRdEn && (regAddr < 9'h101 || regAddr > 9'h109)
		|=> regRdData == 8'h00) else $error("unmapped read not zero");
	a_mixer_wr: assert property (regWrEn && regAddr == 9'h101
		|=> ##1 ctrl.mixerOn == $past(regWrData[3], 2)) else $error("mixer bit lost");
	a_gain_field: assert property (regWrEn && regAddr == 9'h102
		|=> ##1 ctrl.ifGainStageOn == $past(regWrData[3:1], 2)) else $error("gain field lost");
	a_skew_wr: assert property (regWrEn && regAddr == 9'h105
		|=> ##1 ctrl.loSkewQPath == $past(regWrData[6:0], 2)) else $error("skew trim lost");
	a_sense_gate: assert property (liveQ |-> ctrl.senseRun ==
		(ctrl.ifPowerSenseOn & (ctrl.senseAlwaysRun | $past(powerDown)))) else $error("sense gate");
	a_loop_gate: assert property (liveQ |-> ctrl.gainLoopRun ==
		(ctrl.autoGainOn & (ctrl.gainLoopAlwaysRun | $past(powerDown)))) else $error("loop gate");
	c_read: cover property (regRdEn && bankSel == 2'h1 ##1 regRdValid);
	c_write: cover property (regWrEn && regAddr == 9'h101);
	c_pd_run: cover property (liveQ && ctrl.senseRun && !ctrl.senseAlwaysRun);
endmodule : mixer_if_config_regs_monitor

bind mixer_if_config_regs mixer_if_config_regs_monitor #(.AddrWidth(AddrWidth), .NumRegs(NumRegs))
	uMon (.ref_clk(ref_clk), .arst_n(arst_n), .regWrEn(regWrEn), .regRdEn(regRdEn),
	.regAddr(regAddr), .regWrData(regWrData), .bankSel(bankSel), .powerDown(powerDown),
	.regRdData(regRdData), .regRdValid(regRdValid), .ctrl(ctrl));

// File: test_mixer_if_config_regs.sv
// Self-checking bench for the mixer and IF configuration bank
`timescale 1ns/10ps
`include "mixer_if_cfg.svh"
module test_mixer_if_config_regs;
	logic                ref_clk, arst_n, regWrEn, regRdEn, powerDown, regRdValid;
	logic [8:0]          regAddr;
	logic [1:0]          bankSel;
	mixer_if_pkg::byte_t regWrData, regRdData;
	mixer_if_pkg::ctrl_s ctrl;
	mixer_if_pkg::byte_t mdl [9];
	int                  err_total, total_checks, i;
	mixer_if_config_regs dut (.ref_clk(ref_clk), .arst_n(arst_n), .regWrEn(regWrEn),
		.regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData), .bankSel(bankSel),
		.powerDown(powerDown), .regRdData(regRdData), .regRdValid(regRdValid), .ctrl(ctrl));
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// --------------------------------------------------------------------
	// Compare, drive and closing tasks
	// --------------------------------------------------------------------
	task automatic tally_and_finish;
		$display("Checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string nm, input mixer_if_pkg::byte_t ex, input mixer_if_pkg::byte_t got);
		total_checks++;
		if (got !== ex) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk
	task automatic chkCtrl;
		mixer_if_pkg::ctrl_s e;
		e = {mdl[0][3], mdl[0][2], mdl[0][0], mdl[1][7], mdl[1][6], mdl[0][2] & (mdl[1][7] | powerDown),
			mdl[0][0] & (mdl[1][6] | powerDown), mdl[1][5], mdl[1][3:1], mdl[2][6:0], mdl[3][6:0],
			mdl[4][6:0], mdl[5][6:0], mdl[6][6:0], mdl[7][6:0], mdl[8][6:0]};
		total_checks++;
		if (ctrl !== e) begin
			err_total++;
			$display("Error ctrl expected %h seen %h", e, ctrl);
		end
	endtask : chkCtrl
	task automatic wr(input logic [8:0] a, input mixer_if_pkg::byte_t d);
		regWrEn = 1'b1;
		regAddr = a;
		regWrData = d;
		@(negedge ref_clk);
		regWrEn = 1'b0;
		if (a >= 9'h101 && a <= 9'h109) mdl[a - 9'h101] = d;
		// Idle cycle so the next strobe rises on a later edge
		@(negedge ref_clk);
	endtask : wr
	task automatic rd(input logic [8:0] a);
		int n;
		mixer_if_pkg::byte_t e;
		e = (bankSel == 2'h1 && a >= 9'h101 && a <= 9'h109) ? mdl[a - 9'h101] : 8'h00;
		regRdEn = 1'b1;
		regAddr = a;
		@(negedge ref_clk);
		regRdEn = 1'b0;
		n = 0;
		while (regRdValid !== 1'b1 && n < 4) begin
			@(negedge ref_clk);
			n++;
		end
		if (regRdValid !== 1'b1) begin
			err_total++;
			$display("Error read valid expected 1 seen timeout");
			tally_and_finish();
		end else begin
			chk($sformatf("read %h", a), e, regRdData);
			// Idle cycle so the next strobe rises on a later edge
			@(negedge ref_clk);
		end
	endtask : rd
	task automatic rst;
		arst_n = 1'b0;
		repeat (20) @(negedge ref_clk);
		arst_n = 1'b1;
		mdl = '{`MIF_RST_MODE_ENABLES, `MIF_RST_IF_CHAIN, `MIF_RST_COMMON_MODE, `MIF_RST_LO_SKEW_I,
			`MIF_RST_LO_SKEW_Q, `MIF_RST_NULL, `MIF_RST_NULL, `MIF_RST_NULL, `MIF_RST_NULL};
		repeat (2) @(negedge ref_clk);
	endtask : rst
	task automatic rdAll;
		for (i = 0; i < 9; i++) rd(9'h101 + 9'(i));
		chkCtrl();
	endtask : rdAll
	// --------------------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------------------
	initial begin
		err_total = 0;
		total_checks = 0;
		{arst_n, regWrEn, regRdEn, powerDown, regAddr, regWrData} = '0;
		bankSel = 2'h1;
		void'($urandom(13814));
		rst();
		rdAll();
		powerDown = 1'b1;
		repeat (2) @(negedge ref_clk);
		chkCtrl();
		repeat (6) begin
			powerDown = 1'($urandom_range(0, 1));
			for (i = 0; i < 9; i++) wr(9'h101 + 9'(i), 8'($urandom));
			repeat (2) @(negedge ref_clk);
			rdAll();
		end
		wr(9'h103, 8'((238 * 5 / 10 + 807 + 5) / 10));
		rd(9'h103);
		wr(9'h103, 8'((238 * 20 / 10 + 13 + 5) / 10));
		rd(9'h103);
		wr(9'h103, 8'((3 * (128 - 95) + 807 + 5) / 10));
		for (i = 0; i < 4; i++) wr(9'h106 + 9'(i), 8'h5F);
		wr(9'h100, 8'hA5);
		wr(9'h10A, 8'h5A);
		rd(9'h100);
		rd(9'h10A);
		rdAll();
		bankSel = 2'h0;
		rd(9'h101);
		bankSel = 2'h2;
		rd(9'h105);
		bankSel = 2'h1;
		rst();
		rdAll();
		tally_and_finish();
	end
endmodule : test_mixer_if_config_regs
